// ==== design/fel_envelope.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fel_consts.svh"

// What this block does
// R1 - attack exponential, decays linear in log attenuation
// R2 - leave attack at 0, first decay at level
// R3 - key-on attack toward 0 at scaled rate
// R4 - at 0 enter first decay automatically
// R5 - past level enter second decay until key-off
// R6 - key-off releases toward maximum attenuation
// R7 - all rates key-scaled by 2-bit depth
// R8 - first decay level 4 bits, 3 dB steps
// R9 - add 7-bit total level, 0.75 dB step
// R10 - am scaled by 2-bit channel sensitivity
// R11 - am only where slot enable bit set
// R12 - noise enable turns last slot into noise
// R13 - noise clock is clock over 32 times divider
// R14 - noise repeats every 2^17-1 noise clocks
// R15 - noise slot envelope non-logarithmic
// R16 - oscillator frequency from 8-bit field
// R17 - 2-bit waveform drives both pm and am
// R18 - one 7-bit depth, top bit selects target
// R19 - pm two's complement, am unsigned
// R20 - test bit holds and restarts oscillator
// R21 - only oscillator reset test bit written high
// R22 - 32-slot time-division schedule, eight channels
// R23 - rate is 2R plus offset, clamp 63
// R24 - release input rate is 2RR plus 1
// R25 - key code: 3-bit octave, 4-bit note
// R26 - per-slot phase, attenuation; attack from current
module fel_envelope #(
  parameter int SLOTS = 32,
  parameter int CHANS = 8
) (
  input wire logic sys_clk_i, // master clock
  input wire logic sys_rst_i, // async reset, high
  input wire logic [7:0] reg_addr_i, // register address
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [7:0] reg_rdata_o, // read data, cycle after strobe
  output logic [4:0] env_slot_o, // slot of env_atten_o
  output fel_pkg::fel_atten_t env_atten_o, // attenuation to sine_lookup_unit
  output logic noise_slot_o, // this slot is the noise slot
  output logic noise_bit_o, // noise source output
  output logic signed [7:0] pm_o, // phase modulation to pitch path
  output logic [7:0] am_o, // amplitude modulation value
  output logic test_mode_o // illegal test bit written
);
  import fel_pkg::*;

  function automatic logic fel_hit(input logic [7:0] a, input logic [7:0] base,
                                   input logic [7:0] span);
    fel_hit = (a & ~span) == base;
  endfunction

  function automatic logic [5:0] fel_eff_rate(input logic [4:0] r, input logic [4:0] rks);
    logic [6:0] sum;
    sum = {1'b0, r, 1'b0} + {2'b00, rks};
    fel_eff_rate = (sum > 7'd63) ? `FEL_RATE_MAX : sum[5:0];
  endfunction

  // global settings
  logic [7:0] test_r;
  logic ne_r;
  logic [4:0] noise_rate_div_r;
  logic [7:0] slow_osc_rate_r;
  logic [6:0] pmd_r;
  logic [6:0] amd_r;
  fel_wave_t wave_r;
  // per channel and per slot parameters
  logic [6:0] kc_r [CHANS];
  logic [1:0] ams_r [CHANS];
  logic [6:0] tl_r [SLOTS];
  logic [1:0] ks_r [SLOTS];
  logic [4:0] ar_r [SLOTS];
  logic [4:0] d1r_r [SLOTS];
  logic [4:0] d2r_r [SLOTS];
  logic [3:0] d1l_r [SLOTS];
  logic [3:0] rr_r [SLOTS];
  logic [SLOTS-1:0] amen_r;
  logic [SLOTS-1:0] kon_r;
  // envelope state
  logic [SLOTS-1:0] kprev_r;
  fel_phase_t ph_r [SLOTS];
  fel_atten_t att_r [SLOTS];
  logic [4:0] slot_r;
  logic [11:0] egc_r;
  fel_phase_t ph_nxt;
  fel_atten_t att_nxt;
  // noise and read data
  logic [9:0] ndiv_r;
  logic [16:0] lfsr_r;
  logic [7:0] rd_data_r;
  logic [7:0] rd_mux;

  // register decode
  wire [4:0] w_slot = reg_addr_i[4:0];
  wire [2:0] w_ch = reg_addr_i[2:0];
  wire wr_test = reg_wr_i && (reg_addr_i == `FEL_A_TEST);
  wire wr_keyon = reg_wr_i && (reg_addr_i == `FEL_A_KEYON);
  wire wr_noise = reg_wr_i && (reg_addr_i == `FEL_A_NOISE);
  wire wr_slow_osc_rate = reg_wr_i && (reg_addr_i == `FEL_A_SLOW_OSC_RATE);
  wire wr_depth = reg_wr_i && (reg_addr_i == `FEL_A_DEPTH);
  wire wr_wave = reg_wr_i && (reg_addr_i == `FEL_A_WAVE);
  wire wr_kc = reg_wr_i && fel_hit(reg_addr_i, `FEL_B_KC, `FEL_M_CH);
  wire wr_ams = reg_wr_i && fel_hit(reg_addr_i, `FEL_B_AMS, `FEL_M_CH);
  wire wr_tl = reg_wr_i && fel_hit(reg_addr_i, `FEL_B_TL, `FEL_M_SLOT);
  wire wr_ksar = reg_wr_i && fel_hit(reg_addr_i, `FEL_B_KSAR, `FEL_M_SLOT);
  wire wr_amd1r = reg_wr_i && fel_hit(reg_addr_i, `FEL_B_AMD1R, `FEL_M_SLOT);
  wire wr_d2r = reg_wr_i && fel_hit(reg_addr_i, `FEL_B_D2R, `FEL_M_SLOT);
  wire wr_d1lrr = reg_wr_i && fel_hit(reg_addr_i, `FEL_B_D1LRR, `FEL_M_SLOT);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      test_r <= 8'h00;
      ne_r <= 1'b0;
      noise_rate_div_r <= 5'h00;
      slow_osc_rate_r <= 8'h00;
      pmd_r <= 7'h00;
      amd_r <= 7'h00;
      wave_r <= FEL_SAW;
      amen_r <= '0;
      kon_r <= '0;
      for (int c = 0; c < CHANS; c++) begin
        kc_r[c] <= 7'h00;
        ams_r[c] <= 2'h0;
      end
      for (int s = 0; s < SLOTS; s++) begin
        tl_r[s] <= 7'h00;
        ks_r[s] <= 2'h0;
        ar_r[s] <= 5'h00;
        d1r_r[s] <= 5'h00;
        d2r_r[s] <= 5'h00;
        d1l_r[s] <= 4'h0;
        rr_r[s] <= 4'h0;
      end
    end else begin
      if (wr_test) test_r <= reg_wdata_i;
      if (wr_noise) begin
        ne_r <= reg_wdata_i[`FEL_NE_BIT];
        noise_rate_div_r <= reg_wdata_i[4:0];
      end
      if (wr_slow_osc_rate) slow_osc_rate_r <= reg_wdata_i;
      if (wr_depth && reg_wdata_i[`FEL_DEPTH_SEL_BIT]) pmd_r <= reg_wdata_i[6:0]; // R18
      if (wr_depth && !reg_wdata_i[`FEL_DEPTH_SEL_BIT]) amd_r <= reg_wdata_i[6:0]; // R18
      if (wr_wave) wave_r <= fel_wave_t'(reg_wdata_i[1:0]);
      // operator bits map to slots ch, ch+16, ch+8, ch+24
      if (wr_keyon) begin
        kon_r[{2'b00, reg_wdata_i[2:0]}] <= reg_wdata_i[3];
        kon_r[{2'b10, reg_wdata_i[2:0]}] <= reg_wdata_i[4];
        kon_r[{2'b01, reg_wdata_i[2:0]}] <= reg_wdata_i[5];
        kon_r[{2'b11, reg_wdata_i[2:0]}] <= reg_wdata_i[6];
      end
      if (wr_kc) kc_r[w_ch] <= reg_wdata_i[6:0];
      if (wr_ams) ams_r[w_ch] <= reg_wdata_i[1:0];
      if (wr_tl) tl_r[w_slot] <= reg_wdata_i[6:0];
      if (wr_ksar) begin
        ks_r[w_slot] <= reg_wdata_i[7:6];
        ar_r[w_slot] <= reg_wdata_i[4:0];
      end
      if (wr_amd1r) begin
        amen_r[w_slot] <= reg_wdata_i[`FEL_AMEN_BIT];
        d1r_r[w_slot] <= reg_wdata_i[4:0];
      end
      if (wr_d2r) d2r_r[w_slot] <= reg_wdata_i[4:0];
      if (wr_d1lrr) begin
        d1l_r[w_slot] <= reg_wdata_i[7:4];
        rr_r[w_slot] <= reg_wdata_i[3:0];
      end
    end
  end

  // current slot of the time-division schedule
  wire [2:0] s_ch = slot_r[2:0]; // R22
  wire [6:0] s_kc = kc_r[s_ch];
  fel_phase_t cur_ph;
  fel_atten_t cur_att;
  assign cur_ph = ph_r[slot_r]; // R26
  assign cur_att = att_r[slot_r]; // R26
  wire k_on = kon_r[slot_r];
  wire k_edge = k_on && !kprev_r[slot_r];
  wire ns_slot = ne_r && (slot_r == `FEL_NOISE_SLOT); // R12

  // octave and top two note bits form the scaling code
  wire [4:0] s_rks = s_kc[6:2] >> (2'd3 - ks_r[slot_r]); // R7 R25
  wire [4:0] in_rate = (cur_ph == FEL_ATT) ? ar_r[slot_r] :
                       (cur_ph == FEL_DEC1) ? d1r_r[slot_r] :
                       (cur_ph == FEL_DEC2) ? d2r_r[slot_r] :
                       {rr_r[slot_r], 1'b1}; // R24
  wire [5:0] rate = fel_eff_rate(in_rate, s_rks); // R23 R7

  // slow rates tick rarely, fast rates take bigger steps
  wire [3:0] r_hi = rate[5:2];
  wire [3:0] sh = (r_hi >= `FEL_EG_FAST_RATE) ? 4'd0 : `FEL_EG_FAST_RATE - r_hi;
  wire [11:0] sh_mask = (12'h001 << sh) - 12'h001;
  wire [11:0] eg_sh = egc_r >> sh;
  wire tick = (rate != 6'h00) && ((egc_r & sh_mask) == 12'h000) &&
              (eg_sh[2:0] < {1'b1, rate[1:0]});
  wire [2:0] inc = (r_hi > `FEL_EG_FAST_RATE) ? 3'(r_hi - `FEL_EG_FAST_RATE) : 3'd1;

  // attack step shrinks with attenuation: exponential approach to zero
  wire [9:0] att_dec = 10'(({4'h0, cur_att[9:4]} + 10'd1) * {7'h00, inc}); // R1
  wire [9:0] att_sub = (cur_att > att_dec) ? cur_att - att_dec : 10'h000;
  // noise slot: steps grow as it quietens, a straight line in amplitude
  wire [9:0] lin_step = ns_slot ? 10'({7'h00, inc} << cur_att[9:8]) : {7'h00, inc}; // R15
  wire [10:0] att_add = {1'b0, cur_att} + {1'b0, lin_step}; // R1
  wire [9:0] att_up = att_add[10] ? `FEL_ATTEN_MAX : att_add[9:0];
  wire [9:0] d1l_lvl = (d1l_r[slot_r] == 4'hF) ? `FEL_D1L_TOP : {1'b0, d1l_r[slot_r], 5'h00}; // R8

  always_comb begin
    ph_nxt = cur_ph;
    att_nxt = cur_att;
    if (k_edge) begin
      ph_nxt = FEL_ATT; // R3 R26
    end else if (!k_on && (cur_ph != FEL_REL)) begin
      ph_nxt = FEL_REL; // R6
    end else begin
      case (cur_ph)
        FEL_ATT: begin
          if (cur_att == 10'h000) begin
            ph_nxt = FEL_DEC1; // R2 R4
          end else if (rate == `FEL_RATE_MAX) begin
            att_nxt = 10'h000;
          end else if (tick) begin
            att_nxt = att_sub; // R3
          end
        end
        FEL_DEC1: begin
          if (cur_att >= d1l_lvl) begin
            ph_nxt = FEL_DEC2; // R2 R5
          end else if (tick) begin
            att_nxt = att_up; // R4
          end
        end
        FEL_DEC2: begin
          if (tick) att_nxt = att_up; // R5
        end
        FEL_REL: begin
          if (tick) att_nxt = att_up; // R6
        end
        default: ph_nxt = FEL_REL;
      endcase
    end
  end

  // output attenuation: envelope, total level, amplitude modulation
  wire [10:0] am_term = (amen_r[slot_r] && (ams_r[s_ch] != 2'h0)) ?
                        11'(({3'h0, am_o} << ams_r[s_ch]) >> 2) : 11'h000; // R10 R11
  wire [11:0] tot = {2'b00, cur_att} + {2'b00, tl_r[slot_r], 3'h0} + {1'b0, am_term}; // R9
  wire [9:0] tot_sat = (tot > 12'h3FF) ? `FEL_ATTEN_MAX : tot[9:0];

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slot_r <= 5'h00;
      egc_r <= 12'h000;
      kprev_r <= '0;
      env_slot_o <= 5'h00;
      env_atten_o <= `FEL_ATTEN_MAX;
      noise_slot_o <= 1'b0;
      for (int s = 0; s < SLOTS; s++) begin
        ph_r[s] <= FEL_REL;
        att_r[s] <= `FEL_ATTEN_MAX;
      end
    end else begin
      slot_r <= slot_r + 5'd1; // R22
      if (slot_r == 5'd31) egc_r <= egc_r + 12'd1;
      kprev_r[slot_r] <= k_on;
      ph_r[slot_r] <= ph_nxt; // R26
      att_r[slot_r] <= att_nxt; // R26
      env_slot_o <= slot_r;
      env_atten_o <= tot_sat; // R9
      noise_slot_o <= ns_slot; // R12
    end
  end

  // noise source: prescale by 32 times the divider field, 0 stops it
  wire [9:0] ndiv_lim = {noise_rate_div_r, 5'h00} - 10'd1;
  wire ntick = (noise_rate_div_r != 5'h00) && (ndiv_r >= ndiv_lim); // R13

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ndiv_r <= 10'h000;
      lfsr_r <= `FEL_LFSR_SEED;
      noise_bit_o <= 1'b0;
      test_mode_o <= 1'b0;
    end else begin
      ndiv_r <= ntick ? 10'h000 : ndiv_r + 10'd1; // R13
      if (ntick) lfsr_r <= {lfsr_r[15:0], lfsr_r[16] ^ lfsr_r[13]}; // R14
      noise_bit_o <= lfsr_r[16];
      test_mode_o <= |(test_r & ~(8'h01 << `FEL_TEST_LFO_RST)); // R21
    end
  end

  fel_lfo u_lfo (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .rate_i(slow_osc_rate_r), // R16
    .wave_i(wave_r), // R17
    .pm_depth_i(pmd_r),
    .am_depth_i(amd_r),
    .hold_i(test_r[`FEL_TEST_LFO_RST]), // R20
    .rnd_i(lfsr_r[7:0]),
    .pm_o(pm_o), // R19
    .am_o(am_o) // R19
  );

  // read side
  always_comb begin
    case (reg_addr_i)
      `FEL_A_STATUS: rd_mux = {noise_bit_o, 2'b00, slot_r};
      `FEL_A_TEST: rd_mux = test_r;
      `FEL_A_LFOAM: rd_mux = am_o;
      `FEL_A_LFOPM: rd_mux = pm_o;
      `FEL_A_NOISE: rd_mux = {ne_r, 2'b00, noise_rate_div_r};
      `FEL_A_SLOW_OSC_RATE: rd_mux = slow_osc_rate_r;
      `FEL_A_WAVE: rd_mux = {6'h00, wave_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata_o = rd_data_r;

endmodule // fel_envelope

`default_nettype wire

// ==== design/fel_consts.svh ====
`ifndef FEL_CONSTS_SVH
`define FEL_CONSTS_SVH

// register byte addresses
`define FEL_A_STATUS 8'h00
`define FEL_A_TEST 8'h01
`define FEL_A_LFOAM 8'h02
`define FEL_A_LFOPM 8'h03
`define FEL_A_KEYON 8'h08
`define FEL_A_NOISE 8'h0F
`define FEL_A_SLOW_OSC_RATE 8'h18
`define FEL_A_DEPTH 8'h19
`define FEL_A_WAVE 8'h1B
// per-channel blocks of 8, per-slot blocks of 32
`define FEL_B_KC 8'h28
`define FEL_B_AMS 8'h38
`define FEL_B_TL 8'h60
`define FEL_B_KSAR 8'h80
`define FEL_B_AMD1R 8'hA0
`define FEL_B_D2R 8'hC0
`define FEL_B_D1LRR 8'hE0
`define FEL_M_CH 8'h07
`define FEL_M_SLOT 8'h1F

// field positions
`define FEL_TEST_LFO_RST 1
`define FEL_NE_BIT 7
`define FEL_DEPTH_SEL_BIT 7
`define FEL_AMEN_BIT 7

// reset values and scale
`define FEL_ATTEN_MAX 10'h3FF
`define FEL_RATE_MAX 6'h3F
`define FEL_D1L_TOP 10'h3E0
`define FEL_LFSR_SEED 17'h1FFFF
`define FEL_NOISE_SLOT 5'h1F

// timing counts
`define FEL_NOISE_PRE 5
`define FEL_EG_FAST_RATE 4'd11

`endif

// ==== design/fel_pkg.sv ====
package fel_pkg;

  typedef enum logic [1:0] {
    FEL_ATT = 2'b00,
    FEL_DEC1 = 2'b01,
    FEL_DEC2 = 2'b11,
    FEL_REL = 2'b10
  } fel_phase_t;

  typedef enum logic [1:0] {
    FEL_SAW = 2'b00,
    FEL_SQR = 2'b01,
    FEL_TRI = 2'b10,
    FEL_RND = 2'b11
  } fel_wave_t;

  typedef logic [9:0] fel_atten_t;

endpackage

// ==== design/fel_lfo.sv ====
`timescale 1ns/1ps
`default_nettype none

module fel_lfo #(
  parameter int ACC_W = 28
) (
  input wire logic sys_clk_i, // master clock
  input wire logic sys_rst_i, // async reset, high
  input wire logic [7:0] rate_i, // slow_osc_rate
  input wire fel_pkg::fel_wave_t wave_i, // waveform select
  input wire logic [6:0] pm_depth_i, // pitch_mod_depth
  input wire logic [6:0] am_depth_i, // ampl_mod_depth
  input wire logic hold_i, // oscillator reset test bit
  input wire logic [7:0] rnd_i, // random source
  output logic signed [7:0] pm_o, // phase modulation, two's complement
  output logic [7:0] am_o // amplitude modulation, unsigned
);
  import fel_pkg::*;

  logic [ACC_W-1:0] phase_r;
  logic [ACC_W-1:0] phase_nxt;
  logic [7:0] rnd_r;
  logic [7:0] amp_w;
  logic [7:0] pmw;

  // upper nibble is an octave, lower nibble a mantissa: wide range, few bits
  wire [ACC_W-1:0] step = ACC_W'({1'b1, rate_i[3:0]}) << rate_i[7:4]; // R16
  wire [7:0] ph = phase_r[ACC_W-1:ACC_W-8];
  wire [7:0] tri_w = ph[7] ? ~{ph[6:0], 1'b0} : {ph[6:0], 1'b0};

  // held at zero while the test bit stands, restarts at the wave start
  assign phase_nxt = hold_i ? '0 : phase_r + step; // R20

  always_comb begin
    case (wave_i) // R17
      FEL_SAW: begin
        amp_w = ~ph;
        pmw = ph ^ 8'h80;
      end
      FEL_SQR: begin
        amp_w = ph[7] ? 8'h00 : 8'hFF;
        pmw = ph[7] ? 8'h80 : 8'h7F;
      end
      FEL_TRI: begin
        amp_w = ~tri_w;
        pmw = tri_w ^ 8'h80;
      end
      default: begin
        amp_w = rnd_r;
        pmw = rnd_r;
      end
    endcase
  end

  // depth in 1/128 steps, pm stays signed
  wire signed [15:0] pm_prod = $signed(pmw) * $signed({1'b0, pm_depth_i}); // R18 R19
  wire [14:0] am_prod = amp_w * am_depth_i; // R18 R19

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_r <= '0;
      rnd_r <= 8'h00;
      pm_o <= 8'sh00;
      am_o <= 8'h00;
    end else begin
      phase_r <= phase_nxt;
      if (phase_nxt[ACC_W-1:ACC_W-8] != ph) begin
        rnd_r <= rnd_i;
      end
      pm_o <= pm_prod[14:7];
      am_o <= am_prod[14:7];
    end
  end

endmodule // fel_lfo

`default_nettype wire

// ==== verif/fel_envelope_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module fel_env_mon (
  input wire logic sys_clk_i, // master clock
  input wire logic sys_rst_i, // async reset, high
  input wire logic [7:0] reg_addr_i, // register address
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic [4:0] env_slot_o, // slot index
  input wire logic noise_slot_o, // noise slot flag
  input wire logic signed [7:0] pm_o, // phase modulation
  input wire logic [7:0] am_o, // amplitude modulation
  input wire logic test_mode_o // test mode flag
);
  logic [1:0] run_r;
  logic noise_en_r;
  logic hold_r;
  logic amd_zero_r;
  wire logic wr_test = reg_wr_i && (reg_addr_i == 8'h01);
  wire logic wr_noise = reg_wr_i && (reg_addr_i == 8'h0F);
  wire logic wr_amd = reg_wr_i && (reg_addr_i == 8'h19) && !reg_wdata_i[7];

  // shadows of the control bits; run_r skips the edges where $past still sees reset
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_r <= 2'h0;
      noise_en_r <= 1'b0;
      hold_r <= 1'b0;
      amd_zero_r <= 1'b1;
    end else begin
      run_r <= (run_r == 2'h3) ? run_r : run_r + 2'h1;
      noise_en_r <= wr_noise ? reg_wdata_i[7] : noise_en_r;
      hold_r <= wr_test ? reg_wdata_i[1] : hold_r;
      amd_zero_r <= wr_amd ? (reg_wdata_i[6:0] == 7'h00) : amd_zero_r;
    end
  end

  default clocking mon_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_slot_step: assert property (run_r == 2'h3 |-> env_slot_o == $past(env_slot_o) + 5'h01)
    else $error("slot index did not advance by one");
  a_noise_last: assert property (noise_slot_o |-> env_slot_o == 5'h1F)
    else $error("noise slot flag outside the last slot");
  a_noise_gate: assert property (noise_slot_o |-> noise_en_r || $past(noise_en_r))
    else $error("noise slot flag while noise disabled");
  a_noise_on: assert property (env_slot_o == 5'h1F && noise_en_r && $past(noise_en_r, 2)
    |-> noise_slot_o)
    else $error("noise slot flag missing");
  a_test_enter: assert property (wr_test && (reg_wdata_i & 8'hFD) != 8'h00
    |-> ##2 test_mode_o)
    else $error("test mode not entered");
  a_test_leave: assert property (wr_test && (reg_wdata_i & 8'hFD) == 8'h00
    |-> ##2 !test_mode_o)
    else $error("test mode not left");
  a_lfo_hold: assert property (hold_r && $past(hold_r, 4) |-> $stable(am_o) && $stable(pm_o))
    else $error("modulation moved while held");
  a_am_zero: assert property (amd_zero_r && $past(amd_zero_r, 4) |-> am_o == 8'h00)
    else $error("amplitude modulation with zero depth");
endmodule // fel_env_mon

`default_nettype wire

// ==== verif/fel_op_sink.sv ====
`timescale 1ns/1ps
`default_nettype none

module fel_op_sink (
  input wire logic sys_clk_i, // master clock
  input wire logic sys_rst_i, // async reset, high
  input wire logic [4:0] env_slot_i, // slot of incoming value
  input wire fel_pkg::fel_atten_t env_atten_i, // attenuation for that slot
  output var fel_pkg::fel_atten_t att_o [32] // last value seen per slot
);
  // one slot per clock, so each entry refreshes every 32 cycles
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 32; i++) att_o[i] <= 10'h3FF;
    end else begin
      att_o[env_slot_i] <= env_atten_i;
    end
  end
endmodule // fel_op_sink

`default_nettype wire

// ==== verif/fel_envelope_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module fel_envelope_tb_top;
  import fel_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [4:0] env_slot_o;
  fel_atten_t env_atten_o;
  logic noise_slot_o;
  logic noise_bit_o;
  logic signed [7:0] pm_o;
  logic [7:0] am_o;
  logic test_mode_o;
  fel_atten_t att_w [32];
  int err_total = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'd85873;

  always #5 sys_clk_i = ~sys_clk_i;

  fel_envelope fel_envelope_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .env_slot_o(env_slot_o),
    .env_atten_o(env_atten_o), .noise_slot_o(noise_slot_o), .noise_bit_o(noise_bit_o),
    .pm_o(pm_o), .am_o(am_o), .test_mode_o(test_mode_o));
  fel_op_sink fel_op_sink_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .env_slot_i(env_slot_o), .env_atten_i(env_atten_o), .att_o(att_w));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // level 15 sits one step short of full scale
  function automatic fel_atten_t d1l_att(input logic [3:0] l);
    return (l == 4'hF) ? 10'h3E0 : {1'b0, l, 5'h00};
  endfunction
  // output attenuation saturates at full scale
  function automatic fel_atten_t sat_att(input logic [10:0] s);
    return (s > 11'h3FF) ? 10'h3FF : s[9:0];
  endfunction
  task automatic rnd(output logic [7:0] v);
    repeat (8) seed = lfsr_next(seed);
    v = seed[7:0];
  endtask
  task automatic summarize();
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected byte at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_att(input fel_atten_t got, input fel_atten_t exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected atten at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk_reg(reg_rdata_o, exp);
  endtask
  task automatic wait_att(input logic [4:0] s, input fel_atten_t exp);
    int n;
    n = 0;
    while (att_w[s] !== exp && n < 50000) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    chk_att(att_w[s], exp);
    if (att_w[s] !== exp) summarize();
  endtask
  // counts noise slot visits and noise bit changes over a window
  task automatic watch(input int len, output int ns, output int tog);
    logic nb;
    ns = 0;
    tog = 0;
    nb = noise_bit_o;
    repeat (len) begin
      @(posedge sys_clk_i);
      #1 ns += (noise_slot_o === 1'b1);
      tog += (noise_bit_o !== nb);
      nb = noise_bit_o;
    end
  endtask

  initial begin
    logic [7:0] v;
    logic [3:0] lvl;
    int ns;
    int tog;
    repeat (6) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h0F, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h60, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd(v);
      wr(8'h18, v);
      rd(8'h18, v);
      wr(8'h1B, 8'(i));
      rd(8'h1B, 8'(i));
      wr(8'h19, v | 8'h80);
      wr(8'h19, v & 8'h7F);
      repeat (40) @(posedge sys_clk_i);
    end
    // square wave, full depths; held phase sits at the wave start
    wr(8'h1B, 8'h01);
    wr(8'h19, 8'hFF);
    wr(8'h19, 8'h7F);
    wr(8'h01, 8'h02);
    rd(8'h01, 8'h02);
    repeat (40) @(posedge sys_clk_i);
    rd(8'h02, 8'hFD);
    rd(8'h03, 8'h7E);
    wr(8'h01, 8'h04);
    repeat (3) @(posedge sys_clk_i);
    chk_reg({7'h00, test_mode_o}, 8'h01);
    wr(8'h01, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    chk_reg({7'h00, test_mode_o}, 8'h00);
    // slot 0: fast attack, no decay, clamped rate via pitch code
    rnd(v);
    wr(8'h28, v & 8'h7F);
    wr(8'h80, 8'h1F);
    wr(8'hE0, 8'h0F);
    wr(8'h08, 8'h08);
    wait_att(5'd0, 10'h000);
    rnd(v);
    wr(8'h60, v & 8'h7F);
    repeat (70) @(posedge sys_clk_i);
    chk_att(att_w[0], {v[6:0], 3'b000});
    wr(8'h38, 8'h03);
    wr(8'h19, 8'h7F);
    repeat (70) @(posedge sys_clk_i);
    chk_att(att_w[0], {v[6:0], 3'b000});
    // freeze the oscillator so am stays at full depth, then enable am on slot 0
    wr(8'h01, 8'h02);
    wr(8'hA0, 8'h80);
    repeat (70) @(posedge sys_clk_i);
    chk_att(att_w[0], sat_att({1'b0, v[6:0], 3'b000} + 11'h1FA));
    wr(8'h08, 8'h00);
    wait_att(5'd0, 10'h3FF);
    // slot 1: decay settles on the first decay level
    rnd(v);
    lvl = (v[3:0] == 4'h0) ? 4'hE : v[3:0];
    wr(8'h81, 8'h1F);
    wr(8'hA1, 8'h17);
    wr(8'hE1, {lvl, 4'hF});
    wr(8'h08, 8'h09);
    wait_att(5'd1, d1l_att(lvl));
    repeat ((int'(lvl) * 32 + 8) * 32) @(posedge sys_clk_i);
    chk_att(att_w[1], d1l_att(lvl));
    wr(8'h0F, 8'h81);
    rd(8'h0F, 8'h81);
    watch(2048, ns, tog);
    chk_reg(8'(ns), 8'h40);
    chk_reg({7'h00, tog > 0}, 8'h01);
    wr(8'h0F, 8'h80);
    // a tick may still land at the edge of the write
    repeat (2) @(posedge sys_clk_i);
    watch(512, ns, tog);
    chk_reg(8'(tog), 8'h00);
    wr(8'h0F, 8'h00);
    watch(256, ns, tog);
    chk_reg(8'(ns), 8'h00);
    summarize();
  end
endmodule // fel_envelope_tb_top

bind fel_envelope fel_env_mon fel_env_mon_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .env_slot_o(env_slot_o), .noise_slot_o(noise_slot_o), .pm_o(pm_o), .am_o(am_o),
  .test_mode_o(test_mode_o));

`default_nettype wire
